// *** hw/host_cmd_pkg.sv ***
// constants, types and shared layout of the terminal host command executor
// Behaviour
// - each pass tests the request flag; clear skips execution, set runs a command
// - a pending request reads the command number and dispatches one of sixteen handlers
// - handlers fetch their arguments from the three argument bytes after the number
// - results go back to the argument locations, main status always in the result location
// - after results are stored the request flag is cleared to signal completion
// - codes 0..7: read buf, write buf, status/cursor, clear bits, key, pen, reset, trig data
// - codes 8..15: trig addr, attn mask, term type, relay, term info, noop, revision, reserved
// - status changes go to the coax task as mailbox entries of location and change
// - mailbox asks resets of cursor, key empty, polled, unit reset bits and coax reset
// - pending changes accumulate during a pass and are posted once at its end
// - sticky main status bits stay set until a host clear command
// - fatal error and command interrupt bits are never set and read zero
// - aux change bit sets when the new aux byte differs from the previous one
package host_cmd_pkg;

	// ---------------------------------------------------------------
	// register byte offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] OFS_FLAG = 8'h00;
	localparam logic [7:0] OFS_NUM = 8'h04;
	localparam logic [7:0] OFS_ARG0 = 8'h08;
	localparam logic [7:0] OFS_ARG1 = 8'h0C;
	localparam logic [7:0] OFS_ARG2 = 8'h10;
	localparam logic [7:0] OFS_RES = 8'h14;
	localparam logic [7:0] OFS_MAIN = 8'h18;
	localparam logic [7:0] OFS_AUX = 8'h1C;
	localparam logic [7:0] OFS_ISTAT = 8'h20;
	localparam logic [7:0] OFS_IMASK = 8'h24;

	// ---------------------------------------------------------------
	// main status bit positions
	// ---------------------------------------------------------------
	localparam int MS_AUXCHG = 7;
	localparam int MS_TRIG = 6;
	localparam int MS_KEYEMPTY = 5;
	localparam int MS_FATAL = 4;
	localparam int MS_UNITRST = 3;
	localparam int MS_CMDIRQ = 2;
	localparam int MS_BUFMOD = 1;
	localparam int MS_CURSOR = 0;
	localparam int AUX_POLLED = 6;
	localparam logic [7:0] AUX_USED = 8'h7F;
	localparam logic [7:0] COAX_STICKY = 8'h2B;

	// ---------------------------------------------------------------
	// change accumulator bits and mailbox location
	// ---------------------------------------------------------------
	localparam int ACC_CURSOR = 0;
	localparam int ACC_KEYEMPTY = 1;
	localparam int ACC_POLLED = 2;
	localparam int ACC_UNITRST = 3;
	localparam int ACC_POR = 4;
	localparam logic [7:0] MBOX_LOC_MAIN = 8'h01;

	// ---------------------------------------------------------------
	// interrupt bits, identity, reset values
	// ---------------------------------------------------------------
	localparam int INT_DONE = 0;
	localparam int INT_ATTN = 1;
	localparam int INT_BADCMD = 2;
	localparam logic [7:0] REV_ID = 8'h11;
	localparam logic [7:0] VENDOR_ID = 8'h5A;
	localparam logic [7:0] RST_BYTE = 8'h00;

	typedef enum logic [3:0] {
		C_RDBUF, C_WRBUF, C_STATCUR, C_CLRSTAT, C_KEY, C_PEN, C_POR, C_TRIGDATA,
		C_TRIGADDR, C_ATTNMASK, C_TERMTYPE, C_RELAY, C_TERMINFO, C_NOOP, C_REVID,
		C_RESERVED
	} cmd_e;

	typedef enum logic [2:0] {
		S_SCAN = 3'b000,
		S_STAT = 3'b001,
		S_EXEC = 3'b011,
		S_DONE = 3'b010,
		S_MBOX = 3'b110
	} pass_e;

	typedef struct packed {
		logic valid;
		logic [7:0] loc;
		logic [7:0] change;
	} mbox_s;

	typedef struct packed {
		logic valid;
		logic [3:0] cmd;
		logic [7:0] arg0;
		logic [7:0] arg1;
	} coax_req_s;

endpackage : host_cmd_pkg

// *** hw/host_cmd_exec.sv ***
// command executor: avalon register slave, pass sequencer, status and mailbox
`timescale 1ns/1ns
module host_cmd_exec (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [7:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic [7:0] coaxStatus,
	input wire logic [7:0] coaxAux,
	input wire logic [15:0] cursorAddr,
	output host_cmd_pkg::mbox_s mbox,
	output host_cmd_pkg::coax_req_s coaxReq,
	output logic irq
);

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		host_cmd_pkg::pass_e fsm;
		logic cmdFlag;
		logic [3:0] cmdNum;
		logic [2:0][7:0] args;
		logic [7:0] resMain;
		logic [7:0] mainStat;
		logic [7:0] auxPrev;
		logic [7:0] trigData;
		logic [7:0] trigMask;
		logic [3:0] trigAddr;
		logic [7:0] attnMask;
		logic [7:0] termType;
		logic [4:0] accum;
		logic [15:0][7:0] buffer;
		logic [2:0] intStat;
		logic [2:0] intMask;
		logic irq;
		logic waitreq;
		logic [31:0] rdata;
		host_cmd_pkg::mbox_s mbox;
		host_cmd_pkg::coax_req_s creq;
	} state_s;

	state_s st_r;
	state_s st_nxt;

	function automatic logic [31:0] byteWord(input logic [7:0] b);
		byteWord = {24'h000000, b};
	endfunction : byteWord

	logic busReq;
	logic busTake;
	logic [7:0] newAux;
	logic [7:0] newMain;
	logic trigHit;

	assign busReq = read | write;
	assign busTake = busReq & ~st_r.waitreq;
	assign newAux = coaxAux & host_cmd_pkg::AUX_USED;
	assign trigHit = (st_r.trigMask != 8'h00) &&
		((st_r.buffer[st_r.trigAddr] & st_r.trigMask) == (st_r.trigData & st_r.trigMask));

	always_comb begin
		newMain = st_r.mainStat | (coaxStatus & host_cmd_pkg::COAX_STICKY);
		if (newAux != st_r.auxPrev) begin
			newMain[host_cmd_pkg::MS_AUXCHG] = 1'b1;
		end
		if (trigHit) begin
			newMain[host_cmd_pkg::MS_TRIG] = 1'b1;
		end
		newMain[host_cmd_pkg::MS_FATAL] = 1'b0;
		newMain[host_cmd_pkg::MS_CMDIRQ] = 1'b0;
	end

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.mbox.valid = 1'b0;
		st_nxt.creq.valid = 1'b0;
		// one wait cycle per access, then a single low cycle
		st_nxt.waitreq = ~(busReq & st_r.waitreq);
		if (busReq && st_r.waitreq && read) begin
			unique case (address)
				host_cmd_pkg::OFS_FLAG: st_nxt.rdata = {31'h0, st_r.cmdFlag};
				host_cmd_pkg::OFS_NUM: st_nxt.rdata = {28'h0000000, st_r.cmdNum};
				host_cmd_pkg::OFS_ARG0: st_nxt.rdata = byteWord(st_r.args[0]);
				host_cmd_pkg::OFS_ARG1: st_nxt.rdata = byteWord(st_r.args[1]);
				host_cmd_pkg::OFS_ARG2: st_nxt.rdata = byteWord(st_r.args[2]);
				host_cmd_pkg::OFS_RES: st_nxt.rdata = byteWord(st_r.resMain);
				host_cmd_pkg::OFS_MAIN: st_nxt.rdata = byteWord(st_r.mainStat);
				host_cmd_pkg::OFS_AUX: st_nxt.rdata = byteWord(st_r.auxPrev);
				host_cmd_pkg::OFS_ISTAT: st_nxt.rdata = {29'h0, st_r.intStat};
				host_cmd_pkg::OFS_IMASK: st_nxt.rdata = {29'h0, st_r.intMask};
				default: st_nxt.rdata = 32'h00000000;
			endcase
		end
		if (busTake && write) begin
			unique case (address)
				host_cmd_pkg::OFS_FLAG: st_nxt.cmdFlag = writedata[0];
				host_cmd_pkg::OFS_NUM: st_nxt.cmdNum = writedata[3:0];
				host_cmd_pkg::OFS_ARG0: st_nxt.args[0] = writedata[7:0];
				host_cmd_pkg::OFS_ARG1: st_nxt.args[1] = writedata[7:0];
				host_cmd_pkg::OFS_ARG2: st_nxt.args[2] = writedata[7:0];
				host_cmd_pkg::OFS_ISTAT: st_nxt.intStat = st_r.intStat & ~writedata[2:0];
				host_cmd_pkg::OFS_IMASK: st_nxt.intMask = writedata[2:0];
				default: st_nxt.intMask = st_r.intMask;
			endcase
		end

		unique case (st_r.fsm)
			host_cmd_pkg::S_SCAN: begin
				st_nxt.fsm = host_cmd_pkg::S_STAT;
			end
			host_cmd_pkg::S_STAT: begin
				st_nxt.mainStat = newMain;
				st_nxt.auxPrev = newAux;
				if (coaxStatus[host_cmd_pkg::MS_CURSOR]) begin
					st_nxt.accum[host_cmd_pkg::ACC_CURSOR] = 1'b1;
				end
				// attention: a main bit rising under the attention mask
				if (|(newMain & ~st_r.mainStat & st_r.attnMask)) begin
					st_nxt.intStat[host_cmd_pkg::INT_ATTN] = 1'b1;
				end
				if (st_r.cmdFlag) begin
					st_nxt.fsm = host_cmd_pkg::S_EXEC;
				end else begin
					st_nxt.fsm = host_cmd_pkg::S_MBOX;
				end
			end
			host_cmd_pkg::S_EXEC: begin
				st_nxt.fsm = host_cmd_pkg::S_DONE;
				unique case (host_cmd_pkg::cmd_e'(st_r.cmdNum))
					host_cmd_pkg::C_RDBUF: begin
						st_nxt.args[1] = st_r.buffer[st_r.args[0][3:0]];
					end
					host_cmd_pkg::C_WRBUF: begin
						st_nxt.buffer[st_r.args[0][3:0]] = st_r.args[1];
					end
					host_cmd_pkg::C_STATCUR: begin
						st_nxt.args[0] = st_r.auxPrev;
						st_nxt.args[1] = cursorAddr[7:0];
						st_nxt.args[2] = cursorAddr[15:8];
					end
					host_cmd_pkg::C_CLRSTAT: begin
						st_nxt.mainStat = st_r.mainStat & ~st_r.args[0];
						if (st_r.args[0][host_cmd_pkg::MS_CURSOR]) begin
							st_nxt.accum[host_cmd_pkg::ACC_CURSOR] = 1'b1;
						end
						if (st_r.args[0][host_cmd_pkg::MS_KEYEMPTY]) begin
							st_nxt.accum[host_cmd_pkg::ACC_KEYEMPTY] = 1'b1;
						end
						if (st_r.args[0][host_cmd_pkg::MS_UNITRST]) begin
							st_nxt.accum[host_cmd_pkg::ACC_UNITRST] = 1'b1;
						end
						if (st_r.args[1][host_cmd_pkg::AUX_POLLED]) begin
							st_nxt.accum[host_cmd_pkg::ACC_POLLED] = 1'b1;
						end
					end
					host_cmd_pkg::C_POR: begin
						st_nxt.accum[host_cmd_pkg::ACC_POR] = 1'b1;
					end
					host_cmd_pkg::C_TRIGDATA: begin
						st_nxt.trigData = st_r.args[0];
						st_nxt.trigMask = st_r.args[1];
					end
					host_cmd_pkg::C_TRIGADDR: begin
						st_nxt.trigAddr = st_r.args[0][3:0];
					end
					host_cmd_pkg::C_ATTNMASK: begin
						st_nxt.attnMask = st_r.args[0];
					end
					host_cmd_pkg::C_KEY, host_cmd_pkg::C_PEN, host_cmd_pkg::C_RELAY: begin
						st_nxt.creq = '{1'b1, st_r.cmdNum, st_r.args[0], st_r.args[1]};
					end
					host_cmd_pkg::C_TERMTYPE: begin
						st_nxt.termType = st_r.args[0];
						st_nxt.creq = '{1'b1, st_r.cmdNum, st_r.args[0], st_r.args[1]};
					end
					host_cmd_pkg::C_TERMINFO: begin
						st_nxt.args[1] = st_r.termType;
					end
					host_cmd_pkg::C_REVID: begin
						st_nxt.args[1] = host_cmd_pkg::REV_ID;
						st_nxt.args[2] = host_cmd_pkg::VENDOR_ID;
					end
					host_cmd_pkg::C_NOOP: begin
						st_nxt.fsm = host_cmd_pkg::S_DONE;
					end
					host_cmd_pkg::C_RESERVED: begin
						// host misuse is flagged, not executed
						st_nxt.intStat[host_cmd_pkg::INT_BADCMD] = 1'b1;
					end
				endcase
			end
			host_cmd_pkg::S_DONE: begin
				st_nxt.resMain = st_r.mainStat;
				st_nxt.cmdFlag = 1'b0;
				st_nxt.intStat[host_cmd_pkg::INT_DONE] = 1'b1;
				st_nxt.fsm = host_cmd_pkg::S_MBOX;
			end
			host_cmd_pkg::S_MBOX: begin
				// one post per pass keeps the coax task from seeing partial changes
				if (st_r.accum != 5'h00) begin
					st_nxt.mbox = '{1'b1, host_cmd_pkg::MBOX_LOC_MAIN, {3'h0, st_r.accum}};
					st_nxt.accum = 5'h00;
				end
				st_nxt.fsm = host_cmd_pkg::S_SCAN;
			end
			default: begin
				st_nxt.fsm = host_cmd_pkg::S_SCAN;
			end
		endcase
		st_nxt.irq = |(st_nxt.intStat & st_nxt.intMask);
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			st_r <= '0;
			st_r.fsm <= host_cmd_pkg::S_SCAN;
			st_r.waitreq <= 1'b1;
			st_r.mainStat <= host_cmd_pkg::RST_BYTE;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign readdata = st_r.rdata;
	assign waitrequest = st_r.waitreq;
	assign mbox = st_r.mbox;
	assign coaxReq = st_r.creq;
	assign irq = st_r.irq;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!resetn);

	a_skip_clear: assert property (st_r.fsm == host_cmd_pkg::S_STAT && !st_r.cmdFlag
		|=> st_r.fsm == host_cmd_pkg::S_MBOX) else $error("idle pass did not skip");
	a_pass_loop: assert property (st_r.fsm == host_cmd_pkg::S_MBOX
		|=> st_r.fsm == host_cmd_pkg::S_SCAN ##1 st_r.fsm == host_cmd_pkg::S_STAT)
		else $error("pass did not return to the flag test");
	a_dispatch_set: assert property (st_r.fsm == host_cmd_pkg::S_STAT && st_r.cmdFlag
		|=> st_r.fsm == host_cmd_pkg::S_EXEC ##1 st_r.fsm == host_cmd_pkg::S_DONE)
		else $error("pending request not executed");
	a_attn_load: assert property (st_r.fsm == host_cmd_pkg::S_EXEC
		&& st_r.cmdNum == 4'h9 |=> st_r.attnMask == $past(st_r.args[0]))
		else $error("attention mask not loaded from argument");
	a_trig_load: assert property (st_r.fsm == host_cmd_pkg::S_EXEC
		&& st_r.cmdNum == 4'h7 |=> st_r.trigMask == $past(st_r.args[1])
		&& st_r.trigData == $past(st_r.args[0])) else $error("trigger not loaded");
	a_result_first: assert property (st_r.fsm == host_cmd_pkg::S_DONE
		|=> st_r.resMain == $past(st_r.mainStat)) else $error("status not in result");
	a_flag_clear: assert property (st_r.fsm == host_cmd_pkg::S_DONE
		&& !(busTake && write) |=> !st_r.cmdFlag && st_r.intStat[host_cmd_pkg::INT_DONE])
		else $error("request flag not cleared");
	a_flag_held: assert property (st_r.cmdFlag && st_r.fsm != host_cmd_pkg::S_DONE
		&& !(busTake && write) |=> st_r.cmdFlag) else $error("request flag dropped early");
	a_revid_result: assert property (st_r.fsm == host_cmd_pkg::S_EXEC
		&& st_r.cmdNum == 4'hE |=> st_r.args[1] == host_cmd_pkg::REV_ID
		&& st_r.args[2] == host_cmd_pkg::VENDOR_ID) else $error("revision result wrong");
	a_reserved_flag: assert property (st_r.fsm == host_cmd_pkg::S_EXEC
		&& st_r.cmdNum == 4'hF |=> st_r.intStat[host_cmd_pkg::INT_BADCMD])
		else $error("reserved code not flagged");
	a_coax_codes: assert property (st_r.creq.valid |-> st_r.creq.cmd == 4'h4
		|| st_r.creq.cmd == 4'h5 || st_r.creq.cmd == 4'hA || st_r.creq.cmd == 4'hB)
		else $error("coax request for a local command");
	a_mbox_pulse: assert property (st_r.mbox.valid |=> !st_r.mbox.valid)
		else $error("mailbox entry held");
	a_mbox_change: assert property (st_r.mbox.valid |-> st_r.mbox.change[7:5] == 3'h0
		&& st_r.mbox.change != 8'h00) else $error("mailbox entry malformed");
	a_por_post: assert property (st_r.fsm == host_cmd_pkg::S_EXEC
		&& st_r.cmdNum == 4'h6 |-> ##3 st_r.mbox.valid
		&& st_r.mbox.change[host_cmd_pkg::ACC_POR]) else $error("coax reset not posted");
	a_cursor_req: assert property (st_r.fsm == host_cmd_pkg::S_STAT
		&& coaxStatus[host_cmd_pkg::MS_CURSOR] |=> st_r.accum[host_cmd_pkg::ACC_CURSOR])
		else $error("cursor reset not requested");
	a_mbox_once: assert property (st_r.mbox.valid
		|-> $past(st_r.fsm) == host_cmd_pkg::S_MBOX
		&& st_r.mbox.loc == host_cmd_pkg::MBOX_LOC_MAIN && st_r.accum == 5'h00)
		else $error("mailbox posted outside pass end");
	a_accum_hold: assert property (st_r.accum != 5'h00
		&& st_r.fsm != host_cmd_pkg::S_MBOX |=> st_r.accum != 5'h00)
		else $error("pending change dropped before posting");
	a_sticky_hold: assert property ($past(st_r.mainStat[host_cmd_pkg::MS_BUFMOD])
		&& !($past(st_r.fsm) == host_cmd_pkg::S_EXEC && $past(st_r.cmdNum) == 4'h3)
		|-> st_r.mainStat[host_cmd_pkg::MS_BUFMOD]) else $error("sticky bit lost");
	a_sticky_key: assert property ($past(st_r.mainStat[host_cmd_pkg::MS_KEYEMPTY])
		&& !($past(st_r.fsm) == host_cmd_pkg::S_EXEC && $past(st_r.cmdNum) == 4'h3)
		|-> st_r.mainStat[host_cmd_pkg::MS_KEYEMPTY]) else $error("key empty bit lost");
	a_never_set: assert property (!st_r.mainStat[host_cmd_pkg::MS_FATAL]
		&& !st_r.mainStat[host_cmd_pkg::MS_CMDIRQ]) else $error("forbidden bit set");
	a_aux_change: assert property (st_r.fsm == host_cmd_pkg::S_STAT
		&& newAux != st_r.auxPrev |=> st_r.mainStat[host_cmd_pkg::MS_AUXCHG])
		else $error("aux change missed");
	a_aux_steady: assert property (st_r.fsm == host_cmd_pkg::S_STAT
		&& newAux == st_r.auxPrev |=> st_r.mainStat[host_cmd_pkg::MS_AUXCHG]
		== $past(st_r.mainStat[host_cmd_pkg::MS_AUXCHG])) else $error("aux change bit moved");
	a_wait_one: assert property (busReq && st_r.waitreq |=> !st_r.waitreq ##1 st_r.waitreq)
		else $error("wait state not one cycle");
	a_irq_level: assert property (st_r.irq == |(st_r.intStat & st_r.intMask))
		else $error("interrupt line out of step");

endmodule : host_cmd_exec

// *** tb/coax_task_model.sv ***
// coax task model: raw status and aux bits, cleared by mailbox entries
`timescale 1ns/1ns
module coax_task_model (
	input wire logic mclk,
	input wire logic resetn,
	input wire host_cmd_pkg::mbox_s mbox,
	input wire logic [7:0] setStat,
	input wire logic [7:0] setAux,
	output logic [7:0] coaxStatus,
	output logic [7:0] coaxAux
);
	logic [7:0] clrStat;
	logic [7:0] clrAux;
	always_comb begin
		clrStat = 8'h00;
		clrAux = 8'h00;
		if (mbox.valid) begin
			clrStat[0] = mbox.change[0];
			clrStat[5] = mbox.change[1];
			clrAux[6] = mbox.change[2];
			clrStat[3] = mbox.change[3];
			if (mbox.change[4]) begin
				clrStat = 8'hFF;
			end
		end
	end
	// set pulses from the bench win over a same-cycle clear
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			coaxStatus <= 8'h00;
			coaxAux <= 8'h00;
		end else begin
			coaxStatus <= (coaxStatus & ~clrStat) | setStat;
			coaxAux <= (coaxAux & ~clrAux) ^ setAux;
		end
	end
endmodule : coax_task_model

// *** tb/host_cmd_exec_tb.sv ***
// self-checking bench of the host command executor
`timescale 1ns/1ns
module host_cmd_exec_tb;
	logic mclk, resetn, read, write, waitrequest, irq;
	logic [7:0] address, setStat, setAux, coaxStatus, coaxAux;
	logic [31:0] writedata, readdata, d;
	logic [15:0] cursorAddr;
	host_cmd_pkg::mbox_s mbox;
	host_cmd_pkg::coax_req_s coaxReq;
	logic [7:0] r0, r1, r2, rs, ms, lastChg, tt, idx, dat, lastArg;
	logic [3:0] lastReq;
	int error_cnt, checked, mboxCnt, reqCnt, m0, seed;

	host_cmd_exec host_cmd_exec_i (.mclk(mclk), .resetn(resetn), .address(address),
		.read(read), .write(write), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .coaxStatus(coaxStatus), .coaxAux(coaxAux),
		.cursorAddr(cursorAddr), .mbox(mbox), .coaxReq(coaxReq), .irq(irq));
	coax_task_model coax_task_model_i (.mclk(mclk), .resetn(resetn), .mbox(mbox),
		.setStat(setStat), .setAux(setAux), .coaxStatus(coaxStatus), .coaxAux(coaxAux));

	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
			error_cnt++;
		end
	endtask : chk

	task conclude;
		$display("checked=%0d error_cnt=%0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : conclude

	// ---------------------------------------------------------------
	// avalon master: hold until waitrequest is seen low
	// ---------------------------------------------------------------
	task bw(input logic [7:0] a, input logic [31:0] v);
		@(posedge mclk);
		address <= a;
		writedata <= v;
		write <= 1'b1;
		do @(posedge mclk); while (waitrequest !== 1'b0);
		write <= 1'b0;
	endtask : bw

	task br(input logic [7:0] a, output logic [31:0] v);
		@(posedge mclk);
		address <= a;
		read <= 1'b1;
		do @(posedge mclk); while (waitrequest !== 1'b0);
		v = readdata;
		read <= 1'b0;
	endtask : br

	// host order: number and arguments first, then flag, then poll
	task run(input logic [3:0] c, input logic [7:0] a0, input logic [7:0] a1,
		input logic [7:0] a2);
		int n;
		bw(host_cmd_pkg::OFS_NUM, {28'h0, c});
		bw(host_cmd_pkg::OFS_ARG0, {24'h0, a0});
		bw(host_cmd_pkg::OFS_ARG1, {24'h0, a1});
		bw(host_cmd_pkg::OFS_ARG2, {24'h0, a2});
		bw(host_cmd_pkg::OFS_FLAG, 32'h1);
		n = 0;
		d = 32'h1;
		while (d[0] !== 1'b0 && n < 40) begin
			br(host_cmd_pkg::OFS_FLAG, d);
			n++;
		end
		chk(d[0], 1'b0);
		br(host_cmd_pkg::OFS_ARG0, d);
		r0 = d[7:0];
		br(host_cmd_pkg::OFS_ARG1, d);
		r1 = d[7:0];
		br(host_cmd_pkg::OFS_ARG2, d);
		r2 = d[7:0];
		br(host_cmd_pkg::OFS_RES, d);
		rs = d[7:0];
		br(host_cmd_pkg::OFS_MAIN, d);
		ms = d[7:0];
		chk(rs, ms);
		chk({ms[4], ms[2]}, 2'b00);
	endtask : run

	always @(posedge mclk) begin
		if (mbox.valid === 1'b1) begin
			mboxCnt++;
			lastChg = mbox.change;
			chk(mbox.loc, host_cmd_pkg::MBOX_LOC_MAIN);
		end
		if (coaxReq.valid === 1'b1) begin
			reqCnt++;
			lastReq = coaxReq.cmd;
			lastArg = coaxReq.arg0;
		end
	end

	// ---------------------------------------------------------------
	// watchdog and main sequence
	// ---------------------------------------------------------------
	initial begin
		#(8 * 60000);
		error_cnt++;
		conclude();
	end

	initial begin
		{read, write, address, writedata, setStat, setAux} = '0;
		{error_cnt, checked, mboxCnt, reqCnt} = '0;
		seed = 84520;
		cursorAddr = 16'h0000;
		resetn = 1'b0;
		repeat (10) @(posedge mclk);
		resetn <= 1'b1;
		cursorAddr <= 16'($random(seed));
		@(posedge mclk);
		chk({waitrequest, irq}, 2'b10);
		br(8'h40, d);
		chk(d, 32'h0);
		bw(8'h40, 32'hFF);
		m0 = mboxCnt;
		repeat (20) @(posedge mclk);
		chk(mboxCnt, m0);
		$display("end reset and idle");
		bw(host_cmd_pkg::OFS_IMASK, 32'h4);
		for (int c = 0; c < 16; c++) begin
			idx = 8'($random(seed)) & 8'h0F;
			dat = 8'($random(seed));
			m0 = reqCnt;
			lastChg = 8'h00;
			if (c == 0) begin
				run(4'h1, idx, dat, 8'h00);
			end
			if (c == 10) begin
				tt = dat;
			end
			run(4'(c), (c == 0 || c == 10) ? ((c == 0) ? idx : tt) : dat, 8'h00, dat);
			case (c)
				0: chk(r1, dat);
				2: chk({r2, r1, r0}, {cursorAddr, coaxAux & host_cmd_pkg::AUX_USED});
				4, 5, 10, 11: chk({lastReq, lastArg, 20'(reqCnt - m0)}, {4'(c), dat, 20'h1});
				6: chk(lastChg[host_cmd_pkg::ACC_POR], 1'b1);
				12: chk(r1, tt);
				14: chk({r2, r1}, {host_cmd_pkg::VENDOR_ID, host_cmd_pkg::REV_ID});
				15: chk(irq, 1'b1);
				default: ;
			endcase
		end
		bw(host_cmd_pkg::OFS_IMASK, 32'h0);
		repeat (2) @(posedge mclk);
		chk(irq, 1'b0);
		bw(host_cmd_pkg::OFS_IMASK, 32'h4);
		bw(host_cmd_pkg::OFS_ISTAT, 32'h4);
		br(host_cmd_pkg::OFS_ISTAT, d);
		chk({d[2], irq}, 2'b00);
		$display("end command codes");
		// sticky bits stay in main status after the coax side drops its cursor bit
		lastChg = 8'h00;
		setStat <= 8'h2B;
		@(posedge mclk);
		setStat <= 8'h00;
		run(4'hD, 8'h00, 8'h00, 8'h00);
		chk(ms & 8'h2B, 8'h2B);
		chk(lastChg[host_cmd_pkg::ACC_CURSOR], 1'b1);
		m0 = mboxCnt;
		lastChg = 8'h00;
		run(4'h3, 8'h28, 8'h40, 8'h00);
		chk(lastChg[3:1], 3'b111);
		chk(mboxCnt, m0 + 1);
		chk(ms & 8'h28, 8'h00);
		$display("end sticky and mailbox");
		setAux <= 8'h10;
		@(posedge mclk);
		setAux <= 8'h00;
		run(4'hD, 8'h00, 8'h00, 8'h00);
		chk(ms[7], 1'b1);
		run(4'h3, 8'h80, 8'h00, 8'h00);
		run(4'hD, 8'h00, 8'h00, 8'h00);
		chk(ms[7], 1'b0);
		$display("end aux change");
		conclude();
	end
endmodule : host_cmd_exec_tb
